// ### verilog/rpt_timer.sv
// timebase counter with periodic tick timer, APB slave
`timescale 1ns/100ps
module rpt_timer (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // timebase sources, asynchronous
   input  wire logic [3:0]  timebase_src,
   // system state, on mclk
   input  wire logic        cpu_halted,
   input  wire logic        sleep_standby,
   // interrupts and events
   output logic             counter_irq,
   output logic             periodic_irq,
   output logic             wrap_event,
   output logic             match_event,
   output logic [7:0]       periodic_event
);

   // bus-side registers
   logic              counter_enable_bit, next_counter_enable_bit;
   logic              run_in_standby, next_run_in_standby;
   logic [3:0]        divider, next_divider;
   logic [15:0]       count_load, next_count_load;
   logic [15:0]       top_value, next_top_value;
   logic [15:0]       match_value, next_match_value;
   logic              periodic_enable_bit, next_periodic_enable_bit;
   logic [3:0]        period, next_period;
   logic [1:0]        irq_enable, next_irq_enable;
   logic [1:0]        irq_flag, next_irq_flag;
   logic              periodic_irq_enable, next_periodic_irq_enable;
   logic              periodic_flag, next_periodic_flag;
   logic              run_while_halted, next_run_while_halted;
   logic              periodic_run_while_halted, next_periodic_run_while_halted;
   logic [1:0]        timebase_source_select, next_timebase_source_select;
   // timebase-side effective copies
   logic              eff_enable, next_eff_enable;
   logic              eff_standby, next_eff_standby;
   logic [3:0]        eff_divider, next_eff_divider;
   logic [15:0]       eff_top, next_eff_top;
   logic [15:0]       eff_match, next_eff_match;
   logic              eff_penable, next_eff_penable;
   logic [3:0]        eff_period, next_eff_period;
   // sync bookkeeping
   logic [rpt_pkg::SG_NUM-1:0] sync_pending, next_sync_pending;
   logic [1:0]        sync_ticks [rpt_pkg::SG_NUM];
   logic [1:0]        next_sync_ticks [rpt_pkg::SG_NUM];
   // counting
   logic [14:0]       prescaler, next_prescaler;
   logic [15:0]       count, next_count;
   logic [3:0]        tb_meta, tb_sync;
   logic              tb_last;
   // outputs
   logic [31:0]       next_prdata;
   logic              next_pslverr;
   logic              next_counter_irq, next_periodic_irq;
   logic              next_wrap_event, next_match_event;
   logic [7:0]        next_periodic_event;

   // low n bits of the prescaler all ones means a carry out of stage n-1
   function automatic logic carry_out(input logic [14:0] pre, input logic [4:0] n);
      logic [15:0] mask;
      mask = (16'h0001 << n) - 16'h0001;
      return (pre & mask[14:0]) == mask[14:0];
   endfunction

   // byte-lane merge for 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  strb);
      return {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
   endfunction

   // every source is synchronised before the mux; a source switch may give one stray tick
   always_ff @(posedge mclk) begin
      if (rst) begin
         tb_meta <= 4'h0;
         tb_sync <= 4'h0;
         tb_last <= 1'b0;
      end else begin
         tb_meta <= timebase_src;
         tb_sync <= tb_meta;
         tb_last <= tb_sync[timebase_source_select];
      end
   end

   assign pready = 1'b1;

   always_comb begin
      logic        tick;
      logic        setup;
      logic        wr;
      logic [5:0]  idx;
      logic        counter_run;
      logic        periodic_run;
      logic        count_tick;
      logic [rpt_pkg::SG_NUM-1:0] sync_done;
      logic [rpt_pkg::SG_NUM-1:0] sync_start;
      tick  = tb_sync[timebase_source_select] & ~tb_last;
      setup = psel & ~penable;
      wr    = psel & penable & pwrite;
      idx   = paddr[7:2];
      sync_done  = '0;
      sync_start = '0;
      counter_run = eff_enable
                  & (~cpu_halted | run_while_halted)
                  & (~sleep_standby | eff_standby);
      periodic_run = eff_penable
                   & (~cpu_halted | periodic_run_while_halted);
      count_tick = tick & counter_run & carry_out(prescaler, {1'b0, eff_divider});

      next_counter_enable_bit        = counter_enable_bit;
      next_run_in_standby            = run_in_standby;
      next_divider                   = divider;
      next_count_load                = count_load;
      next_top_value                 = top_value;
      next_match_value               = match_value;
      next_periodic_enable_bit       = periodic_enable_bit;
      next_period                    = period;
      next_irq_enable                = irq_enable;
      next_periodic_irq_enable       = periodic_irq_enable;
      next_run_while_halted          = run_while_halted;
      next_periodic_run_while_halted = periodic_run_while_halted;
      next_timebase_source_select    = timebase_source_select;
      next_eff_enable                = eff_enable;
      next_eff_standby               = eff_standby;
      next_eff_divider               = eff_divider;
      next_eff_top                   = eff_top;
      next_eff_match                 = eff_match;
      next_eff_penable               = eff_penable;
      next_eff_period                = eff_period;
      next_sync_pending              = sync_pending;
      next_sync_ticks                = sync_ticks;
      next_prescaler                 = prescaler;
      next_count                     = count;
      next_wrap_event                = 1'b0;
      next_match_event               = 1'b0;
      next_periodic_event            = '0;

      // pending writes complete on the second timebase tick
      for (int g = 0; g < rpt_pkg::SG_NUM; g++) begin
         if (sync_pending[g] && tick) begin
            if (sync_ticks[g] == rpt_pkg::SYNC_TICKS - 2'h1) begin
               sync_done[g]         = 1'b1;
               next_sync_pending[g] = 1'b0;
               next_sync_ticks[g]   = 2'h0;
            end else begin
               next_sync_ticks[g] = sync_ticks[g] + 2'h1;
            end
         end
      end
      if (sync_done[rpt_pkg::SG_CTRL]) begin
         next_eff_enable  = counter_enable_bit;
         next_eff_standby = run_in_standby;
         next_eff_divider = divider;
      end
      if (sync_done[rpt_pkg::SG_TOP]) begin
         next_eff_top = top_value;
      end
      if (sync_done[rpt_pkg::SG_MATCH]) begin
         next_eff_match = match_value;
      end
      if (sync_done[rpt_pkg::SG_PCTRL]) begin
         next_eff_penable = periodic_enable_bit;
         next_eff_period  = period;
      end

      // register writes, committed at the access edge
      if (wr) begin
         case (idx)
            rpt_pkg::IDX_CTRL: if (pstrb[0]) begin
               next_counter_enable_bit = pwdata[rpt_pkg::CTRL_EN_BIT];
               next_divider            = pwdata[rpt_pkg::CTRL_DIV_LSB +: 4];
               next_run_in_standby     = pwdata[rpt_pkg::CTRL_STBY_BIT];
               sync_start[rpt_pkg::SG_CTRL] = 1'b1;
            end
            rpt_pkg::IDX_IRQ_EN: if (pstrb[0]) begin
               next_irq_enable = pwdata[1:0];
            end
            rpt_pkg::IDX_DBG: if (pstrb[0]) begin
               next_run_while_halted = pwdata[0];
            end
            rpt_pkg::IDX_SRC_SEL: if (pstrb[0]) begin
               next_timebase_source_select = pwdata[1:0];
            end
            rpt_pkg::IDX_COUNT: if (|pstrb[1:0]) begin
               next_count_load      = merge16(count_load, pwdata, pstrb);
               sync_start[rpt_pkg::SG_COUNT] = 1'b1;
            end
            rpt_pkg::IDX_TOP: if (|pstrb[1:0]) begin
               next_top_value     = merge16(top_value, pwdata, pstrb);
               sync_start[rpt_pkg::SG_TOP] = 1'b1;
            end
            rpt_pkg::IDX_MATCH: if (|pstrb[1:0]) begin
               next_match_value     = merge16(match_value, pwdata, pstrb);
               sync_start[rpt_pkg::SG_MATCH] = 1'b1;
            end
            rpt_pkg::IDX_PCTRL: if (pstrb[0]) begin
               next_periodic_enable_bit = pwdata[rpt_pkg::PCTRL_EN_BIT];
               next_period              = pwdata[rpt_pkg::PCTRL_PERIOD_LSB +: 4];
               sync_start[rpt_pkg::SG_PCTRL] = 1'b1;
            end
            rpt_pkg::IDX_PIRQ_EN: if (pstrb[0]) begin
               next_periodic_irq_enable = pwdata[0];
            end
            rpt_pkg::IDX_PDBG: if (pstrb[0]) begin
               next_periodic_run_while_halted = pwdata[0];
            end
            default: begin
            end
         endcase
      end
      // a fresh write restarts the transfer so the newest value is the one applied
      for (int g = 0; g < rpt_pkg::SG_NUM; g++) begin
         if (sync_start[g]) begin
            next_sync_pending[g] = 1'b1;
            next_sync_ticks[g]   = 2'h0;
         end
      end

      // shared free-running prescaler
      if (tick) begin
         next_prescaler = prescaler + 15'h0001;
      end

      if (count_tick) begin
         if (count == eff_top) begin
            next_count      = 16'h0000;
            next_wrap_event = 1'b1;
         end else begin
            next_count = count + 16'h0001;
         end
         if (count == eff_match) begin
            next_match_event = 1'b1;
         end
      end
      // a synced count write overrides the count of the same tick
      if (sync_done[rpt_pkg::SG_COUNT]) begin
         next_count = count_load;
      end

      if (tick && periodic_run) begin
         for (int k = 0; k < rpt_pkg::NUM_EVENTS; k++) begin
            next_periodic_event[k] = carry_out(prescaler, 5'(rpt_pkg::EVENT_BASE_LOG - k));
         end
      end

      // flags: the set wins over a same-cycle clear
      next_irq_flag = irq_flag;
      if (wr && idx == rpt_pkg::IDX_IRQ_FLAG && pstrb[0]) begin
         next_irq_flag = irq_flag & ~pwdata[1:0];
      end
      next_irq_flag[rpt_pkg::WRAP_BIT]  |= next_wrap_event;
      next_irq_flag[rpt_pkg::MATCH_BIT] |= next_match_event;

      next_periodic_flag = periodic_flag;
      if (wr && idx == rpt_pkg::IDX_PIRQ_FLAG && pstrb[0] && pwdata[0]) begin
         next_periodic_flag = 1'b0;
      end
      if (tick && periodic_run && eff_period >= rpt_pkg::PERIOD_MIN_CODE
          && eff_period <= rpt_pkg::PERIOD_MAX_CODE
          && carry_out(prescaler, {1'b0, eff_period} + 5'h01)) begin
         next_periodic_flag = 1'b1;
      end

      next_counter_irq  = |(next_irq_flag & next_irq_enable);
      next_periodic_irq = next_periodic_flag & next_periodic_irq_enable;

      // read data is captured in the setup cycle
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      if (setup) begin
         next_prdata = 32'h0000_0000;
         case (idx)
            rpt_pkg::IDX_CTRL: begin
               next_prdata[rpt_pkg::CTRL_EN_BIT]       = counter_enable_bit;
               next_prdata[rpt_pkg::CTRL_DIV_LSB +: 4] = divider;
               next_prdata[rpt_pkg::CTRL_STBY_BIT]     = run_in_standby;
            end
            rpt_pkg::IDX_STATUS:    next_prdata[3:0]  = sync_pending[3:0];
            rpt_pkg::IDX_IRQ_EN:    next_prdata[1:0]  = irq_enable;
            rpt_pkg::IDX_IRQ_FLAG:  next_prdata[1:0]  = irq_flag;
            rpt_pkg::IDX_DBG:       next_prdata[0]    = run_while_halted;
            rpt_pkg::IDX_SRC_SEL:   next_prdata[1:0]  = timebase_source_select;
            rpt_pkg::IDX_COUNT:     next_prdata[15:0] = count;
            rpt_pkg::IDX_TOP:       next_prdata[15:0] = top_value;
            rpt_pkg::IDX_MATCH:     next_prdata[15:0] = match_value;
            rpt_pkg::IDX_PCTRL: begin
               next_prdata[rpt_pkg::PCTRL_EN_BIT]          = periodic_enable_bit;
               next_prdata[rpt_pkg::PCTRL_PERIOD_LSB +: 4] = period;
            end
            rpt_pkg::IDX_PSTATUS:   next_prdata[0]    = sync_pending[rpt_pkg::SG_PCTRL];
            rpt_pkg::IDX_PIRQ_EN:   next_prdata[0]    = periodic_irq_enable;
            rpt_pkg::IDX_PIRQ_FLAG: next_prdata[0]    = periodic_flag;
            rpt_pkg::IDX_PDBG:      next_prdata[0]    = periodic_run_while_halted;
            default:                next_pslverr      = 1'b1;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         counter_enable_bit        <= 1'b0;
         run_in_standby            <= 1'b0;
         divider                   <= 4'h0;
         count_load                <= 16'h0000;
         top_value                 <= rpt_pkg::TOP_RESET;
         match_value               <= rpt_pkg::MATCH_RESET;
         periodic_enable_bit       <= 1'b0;
         period                    <= 4'h0;
         irq_enable                <= 2'h0;
         irq_flag                  <= 2'h0;
         periodic_irq_enable       <= 1'b0;
         periodic_flag             <= 1'b0;
         run_while_halted          <= 1'b0;
         periodic_run_while_halted <= 1'b0;
         timebase_source_select    <= 2'h0;
         eff_enable                <= 1'b0;
         eff_standby               <= 1'b0;
         eff_divider               <= 4'h0;
         eff_top                   <= rpt_pkg::TOP_RESET;
         eff_match                 <= rpt_pkg::MATCH_RESET;
         eff_penable               <= 1'b0;
         eff_period                <= 4'h0;
         sync_pending              <= '0;
         for (int g = 0; g < rpt_pkg::SG_NUM; g++) begin
            sync_ticks[g] <= 2'h0;
         end
         prescaler                 <= 15'h0000;
         count                     <= 16'h0000;
         prdata                    <= 32'h0000_0000;
         pslverr                   <= 1'b0;
         counter_irq               <= 1'b0;
         periodic_irq              <= 1'b0;
         wrap_event                <= 1'b0;
         match_event               <= 1'b0;
         periodic_event            <= 8'h00;
      end else begin
         counter_enable_bit        <= next_counter_enable_bit;
         run_in_standby            <= next_run_in_standby;
         divider                   <= next_divider;
         count_load                <= next_count_load;
         top_value                 <= next_top_value;
         match_value               <= next_match_value;
         periodic_enable_bit       <= next_periodic_enable_bit;
         period                    <= next_period;
         irq_enable                <= next_irq_enable;
         irq_flag                  <= next_irq_flag;
         periodic_irq_enable       <= next_periodic_irq_enable;
         periodic_flag             <= next_periodic_flag;
         run_while_halted          <= next_run_while_halted;
         periodic_run_while_halted <= next_periodic_run_while_halted;
         timebase_source_select    <= next_timebase_source_select;
         eff_enable                <= next_eff_enable;
         eff_standby               <= next_eff_standby;
         eff_divider               <= next_eff_divider;
         eff_top                   <= next_eff_top;
         eff_match                 <= next_eff_match;
         eff_penable               <= next_eff_penable;
         eff_period                <= next_eff_period;
         sync_pending              <= next_sync_pending;
         sync_ticks                <= next_sync_ticks;
         prescaler                 <= next_prescaler;
         count                     <= next_count;
         prdata                    <= next_prdata;
         pslverr                   <= next_pslverr;
         counter_irq               <= next_counter_irq;
         periodic_irq              <= next_periodic_irq;
         wrap_event                <= next_wrap_event;
         match_event               <= next_match_event;
         periodic_event            <= next_periodic_event;
      end
   end

endmodule

// ### verilog/rpt_pkg.sv
// constants for the timebase counter and periodic tick timer
package rpt_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL     = 6'h00;
   localparam logic [5:0] IDX_STATUS   = 6'h01;
   localparam logic [5:0] IDX_IRQ_EN   = 6'h02;
   localparam logic [5:0] IDX_IRQ_FLAG = 6'h03;
   localparam logic [5:0] IDX_DBG      = 6'h05;
   localparam logic [5:0] IDX_SRC_SEL  = 6'h07;
   localparam logic [5:0] IDX_COUNT    = 6'h08;
   localparam logic [5:0] IDX_TOP      = 6'h0a;
   localparam logic [5:0] IDX_MATCH    = 6'h0c;
   localparam logic [5:0] IDX_PCTRL    = 6'h10;
   localparam logic [5:0] IDX_PSTATUS  = 6'h11;
   localparam logic [5:0] IDX_PIRQ_EN  = 6'h12;
   localparam logic [5:0] IDX_PIRQ_FLAG = 6'h13;
   localparam logic [5:0] IDX_PDBG     = 6'h15;

   // field positions
   localparam int CTRL_EN_BIT      = 0;
   localparam int CTRL_DIV_LSB     = 3;
   localparam int CTRL_STBY_BIT    = 7;
   localparam int PCTRL_EN_BIT     = 0;
   localparam int PCTRL_PERIOD_LSB = 3;
   localparam int WRAP_BIT         = 0;
   localparam int MATCH_BIT        = 1;

   // sync groups; the first four equal their status bit positions
   localparam int SG_CTRL  = 0;
   localparam int SG_COUNT = 1;
   localparam int SG_TOP   = 2;
   localparam int SG_MATCH = 3;
   localparam int SG_PCTRL = 4;
   localparam int SG_NUM   = 5;

   // timebase ticks from a write until it takes effect
   localparam logic [1:0] SYNC_TICKS = 2'h2;

   // reset values
   localparam logic [15:0] TOP_RESET   = 16'hffff;
   localparam logic [15:0] MATCH_RESET = 16'h0000;

   // periodic event k fires every 2**(EVENT_BASE_LOG-k) ticks
   localparam int EVENT_BASE_LOG = 13;
   localparam int NUM_EVENTS     = 8;
   // period codes outside this range leave the periodic interrupt off
   localparam logic [3:0] PERIOD_MIN_CODE = 4'h1;
   localparam logic [3:0] PERIOD_MAX_CODE = 4'he;
endpackage

// ### tb/rpt_timer_monitor.sv
// port-level assertions for the timebase counter and periodic tick timer
`timescale 1ns/100ps
module rpt_timer_monitor (
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst,
   // apb
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic       pslverr,
   // interrupts and events
   input wire logic       counter_irq,
   input wire logic       periodic_irq,
   input wire logic       wrap_event,
   input wire logic       match_event,
   input wire logic [7:0] periodic_event
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   chk_wrap_single: assert property (wrap_event |=> !wrap_event)
      else $error("wrap event longer than one cycle");
   chk_match_single: assert property (match_event |=> !match_event)
      else $error("match event longer than one cycle");
   chk_event_nest: assert property (periodic_event[0] |-> &periodic_event)
      else $error("slowest event without all faster events");
   chk_event_gap: assert property (periodic_event[7] |=> !periodic_event[7] [*8])
      else $error("fastest event repeats too soon");
   chk_event_pulse: assert property (periodic_event[3] |=> !periodic_event[3])
      else $error("event longer than one cycle");
   chk_cirq_hold: assert property ($fell(counter_irq) |-> $past(psel) && $past(penable) && $past(pwrite))
      else $error("counter irq fell without a write");
   chk_pirq_hold: assert property ($fell(periodic_irq) |-> $past(psel) && $past(penable) && $past(pwrite))
      else $error("periodic irq fell without a write");
   chk_slverr_phase: assert property (pslverr |-> psel && penable)
      else $error("error response outside access phase");
endmodule
bind rpt_timer rpt_timer_monitor rpt_timer_monitor_i (.mclk(mclk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .counter_irq(counter_irq),
   .periodic_irq(periodic_irq), .wrap_event(wrap_event), .match_event(match_event),
   .periodic_event(periodic_event));

// ### tb/rpt_far_model.sv
// timebase sources and event consumer that measures event spacing
`timescale 1ns/100ps
module rpt_far_model (
   input wire logic        mclk,
   input wire logic        wrap_event,
   input wire logic [7:0]  periodic_event,
   output logic [3:0]      timebase_src,
   output int              wrap_gap,
   output int              pev_gap
);
   logic [6:0] div = 7'h00;
   int         since_wrap = 0;
   int         since_pev = 0;
   // sources are 16..128 bus clocks, well above four times slower
   assign timebase_src = div[6:3];
   always_ff @(posedge mclk) begin
      div <= div + 7'h01;
      since_wrap <= wrap_event ? 1 : since_wrap + 1;
      since_pev <= periodic_event[7] ? 1 : since_pev + 1;
      if (wrap_event) wrap_gap <= since_wrap;
      if (periodic_event[7]) pev_gap <= since_pev;
   end
endmodule

// ### tb/rpt_timer_tb_top.sv
// self-checking bench for the timebase counter and periodic tick timer
`timescale 1ns/100ps
module rpt_timer_tb_top;
   logic        mclk, rst, psel, penable, pwrite, cpu_halted, sleep_standby, err;
   logic        pready, pslverr, counter_irq, periodic_irq, wrap_event, match_event;
   logic [7:0]  paddr, periodic_event;
   logic [3:0]  timebase_src;
   logic [31:0] pwdata, prdata, rd, c;
   int          errors = 0, checks_done = 0, cycles = 0, wrap_gap, pev_gap, i;
   rpt_timer rpt_timer_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .timebase_src(timebase_src),
      .cpu_halted(cpu_halted), .sleep_standby(sleep_standby), .counter_irq(counter_irq),
      .periodic_irq(periodic_irq), .wrap_event(wrap_event), .match_event(match_event),
      .periodic_event(periodic_event));
   rpt_far_model rpt_far_model_i (.mclk(mclk), .wrap_event(wrap_event),
      .periodic_event(periodic_event), .timebase_src(timebase_src),
      .wrap_gap(wrap_gap), .pev_gap(pev_gap));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask
   task automatic rchk(input logic [5:0] idx, input logic [31:0] e, input string n);
      xfer(1'b0, idx, 32'h0);
      chk(n, e, rd);
   endtask
   // software waits for the busy flags before the next write
   task automatic settle(input logic [5:0] idx);
      do xfer(1'b0, idx, 32'h0); while (rd !== 32'h0);
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, cpu_halted, sleep_standby} = '0;
      rst = 1'b1;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      rchk(rpt_pkg::IDX_TOP, 32'hffff, "top reset");
      rchk(rpt_pkg::IDX_CTRL, 32'h0, "ctrl reset");
      xfer(1'b1, 6'h0f, 32'h1);
      chk("unmapped error", 32'h1, {31'h0, err});
      $display("test reset done");
      xfer(1'b1, rpt_pkg::IDX_TOP, 32'h3);
      settle(rpt_pkg::IDX_STATUS);
      xfer(1'b1, rpt_pkg::IDX_MATCH, 32'h1);
      settle(rpt_pkg::IDX_STATUS);
      xfer(1'b1, rpt_pkg::IDX_IRQ_EN, 32'h3);
      xfer(1'b1, rpt_pkg::IDX_CTRL, 32'h1);
      rchk(rpt_pkg::IDX_STATUS, 32'h1, "ctrl busy");
      settle(rpt_pkg::IDX_STATUS);
      for (i = 0; i < 300 && counter_irq !== 1'b1; i++) @(posedge mclk);
      chk("counter irq", 32'h1, {31'h0, counter_irq});
      repeat (100) @(posedge mclk);
      rchk(rpt_pkg::IDX_IRQ_FLAG, 32'h3, "wrap and match flags");
      chk("wrap spacing", 32'd64, wrap_gap);
      xfer(1'b1, rpt_pkg::IDX_IRQ_FLAG, 32'h0);
      rchk(rpt_pkg::IDX_IRQ_FLAG, 32'h3, "flags kept");
      cpu_halted <= 1'b1;
      repeat (20) @(posedge mclk);
      xfer(1'b0, rpt_pkg::IDX_COUNT, 32'h0);
      c = rd;
      repeat (40) @(posedge mclk);
      rchk(rpt_pkg::IDX_COUNT, c, "halted count");
      xfer(1'b1, rpt_pkg::IDX_DBG, 32'h1);
      repeat (20) @(posedge mclk);
      xfer(1'b0, rpt_pkg::IDX_COUNT, 32'h0);
      c = rd;
      repeat (40) @(posedge mclk);
      xfer(1'b0, rpt_pkg::IDX_COUNT, 32'h0);
      chk("count runs halted", 32'h1, {31'h0, rd !== c});
      cpu_halted <= 1'b0;
      sleep_standby <= 1'b1;
      xfer(1'b0, rpt_pkg::IDX_COUNT, 32'h0);
      c = rd;
      repeat (40) @(posedge mclk);
      rchk(rpt_pkg::IDX_COUNT, c, "standby count");
      sleep_standby <= 1'b0;
      xfer(1'b1, rpt_pkg::IDX_CTRL, 32'h0);
      settle(rpt_pkg::IDX_STATUS);
      xfer(1'b1, rpt_pkg::IDX_IRQ_FLAG, 32'h3);
      @(posedge mclk);
      chk("counter irq cleared", 32'h0, {31'h0, counter_irq});
      $display("test counter done");
      xfer(1'b1, rpt_pkg::IDX_SRC_SEL, 32'h1);
      xfer(1'b1, rpt_pkg::IDX_PCTRL, 32'h8);
      settle(rpt_pkg::IDX_PSTATUS);
      xfer(1'b1, rpt_pkg::IDX_PIRQ_EN, 32'h1);
      xfer(1'b1, rpt_pkg::IDX_PCTRL, 32'h9);
      rchk(rpt_pkg::IDX_PSTATUS, 32'h1, "periodic busy");
      for (i = 0; i < 400 && periodic_irq !== 1'b1; i++) @(posedge mclk);
      chk("periodic irq", 32'h1, {31'h0, periodic_irq});
      rchk(rpt_pkg::IDX_PIRQ_FLAG, 32'h1, "periodic flag");
      sleep_standby <= 1'b1;
      repeat (5000) @(posedge mclk);
      chk("event spacing", 32'd2048, pev_gap);
      sleep_standby <= 1'b0;
      xfer(1'b1, rpt_pkg::IDX_PCTRL, 32'h0);
      settle(rpt_pkg::IDX_PSTATUS);
      xfer(1'b1, rpt_pkg::IDX_PIRQ_FLAG, 32'h1);
      @(posedge mclk);
      chk("periodic irq cleared", 32'h0, {31'h0, periodic_irq});
      $display("test periodic done");
      complete_run();
   end
endmodule
